// ==== mhbp_checker.sv ====
`timescale 1ns/100ps
module mhbp_checker
   import mhbp_pkg::*;
(
   input logic                              mclk,
   input logic                              rst,
   input logic [3:0]                        regAddr,
   input logic [31:0]                       regWdata,
   input logic                              regWrite,
   input logic [15:0]                       adOut,
   input logic                              adOe,
   input logic [mhbp_pkg::MHBP_UPPER_W-1:0] upperAddr,
   input logic                              latchStrobe,
   input logic                              readStrobeN,
   input logic                              writeStrobeN,
   input logic [3:0]                        selectN,
   input logic [1:0]                        byteSelectN
);
   import mhbp_pkg::*;
   logic [3:0] mode_reg;
   logic [5:0] hb_reg;
   logic [1:0] arr_reg;
   logic       portOn;
   // shadow of config, only safe because config is written while idle
   always_ff @(posedge mclk) begin
      if (rst) begin
         mode_reg <= MHBP_MAINCFG_RST;
         hb_reg <= MHBP_HBCFG_RST;
         arr_reg <= MHBP_HBCFG2_RST;
      end else if (regWrite) begin
         if (regAddr == MHBP_ADDR_MAINCFG) mode_reg <= regWdata[3:0];
         if (regAddr == MHBP_ADDR_HBCFG) hb_reg <= regWdata[5:0];
         if (regAddr == MHBP_ADDR_HBCFG2) arr_reg <= regWdata[1:0];
      end
   end
   assign portOn = mode_reg == MHBP_MODE_HB16 && hb_reg[3:0] == MHBP_SUB_MUXED;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_addr_hold;
      latchStrobe && adOe && $stable(adOut);
   endsequence
   sequence s_turned;
      !latchStrobe && !adOe;
   endsequence
   property p_inactive;
      !portOn |-> !adOe && !latchStrobe && readStrobeN && writeStrobeN && selectN == 4'hf;
   endproperty
   a_inactive: assert property (p_inactive) else $error("pins active while port off");
   property p_latch;
      $rose(latchStrobe) |-> adOe ##1 s_addr_hold ##1 s_turned;
   endproperty
   a_latch: assert property (p_latch) else $error("latch phase wrong");
   property p_latch_arr;
      latchStrobe |-> arr_reg == MHBP_CS_ALE || arr_reg == MHBP_CS_ALE_TWO;
   endproperty
   a_latch_arr: assert property (p_latch_arr) else $error("latch in wrong arrangement");
   property p_sel;
      selectN != 4'hf |-> selectN[3:2] == 2'h3 && $countones(~selectN) == 1 && arr_reg != MHBP_CS_ALE
         && (arr_reg != MHBP_CS_ONE || selectN == 4'he);
   endproperty
   a_sel: assert property (p_sel) else $error("select pattern wrong");
   property p_byte_lane_selects_off;
      hb_reg[5:4] == MHBP_BYTE_LANE_SELECTS_NONE |-> byteSelectN == 2'h3;
   endproperty
   a_byte_lane_selects_off: assert property (p_byte_lane_selects_off) else $error("byte select while off");
   property p_turn;
      $fell(readStrobeN) || $fell(writeStrobeN) |-> $past(adOe) == 1'b0 && $past(latchStrobe) == 1'b0;
   endproperty
   a_turn: assert property (p_turn) else $error("no turnaround before strobe");
   property p_wlen;
      $fell(writeStrobeN) |=> (!writeStrobeN && adOe) ##1 writeStrobeN;
   endproperty
   a_wlen: assert property (p_wlen) else $error("write strobe shape wrong");
   property p_rd_rel;
      !readStrobeN |-> !adOe && writeStrobeN;
   endproperty
   a_rd_rel: assert property (p_rd_rel) else $error("lines driven during read");
   property p_hold;
      !readStrobeN || !writeStrobeN |-> $stable(upperAddr) && $stable(selectN) && $stable(byteSelectN);
   endproperty
   a_hold: assert property (p_hold) else $error("upper address moved");
endmodule
bind mhbp_host_port mhbp_checker chk (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
   .regWrite(regWrite), .adOut(adOut), .adOe(adOe), .upperAddr(upperAddr), .latchStrobe(latchStrobe),
   .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .selectN(selectN), .byteSelectN(byteSelectN));

// ==== mhbp_host_port.sv ====
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
// How it works
// - host-bus pins active only when mode 0x3
// - sub-mode 0x0 selects multiplexed operation
// - shared lines carry address then data
// - address bits 16 up on dedicated lines
// - latch strobe pulses while address valid, in arrangements 0x0 and 0x3 only
// - read or write strobe qualifies data
// - one of up to two selects asserted, none in arrangement 0x0
// - arrangement field maps latch and selects
// - byte-lane selects mark halves in use
// - value 0x1 disables byte selects
module mhbp_host_port
   import mhbp_pkg::*;
(
   input  wire logic                    mclk,
   input  wire logic                    rst,
   input  wire logic [3:0]              regAddr,
   input  wire logic [31:0]             regWdata,
   input  wire logic                    regWrite,
   input  wire logic                    regRead,
   output      logic [31:0]             regRdata,
   input  wire logic [15:0]             adIn,
   output      logic [15:0]             adOut,
   output      logic                    adOe,
   output      logic [MHBP_UPPER_W-1:0] upperAddr,
   output      logic                    latchStrobe,
   output      logic                    readStrobeN,
   output      logic                    writeStrobeN,
   output      logic [3:0]              selectN,
   output      logic [1:0]              byteSelectN
);
   import mhbp_pkg::*;

   typedef struct packed {
      logic [3:0]             mainCfg;
      logic [5:0]             hbCfg;
      logic [1:0]             hbCfg2;
      logic [MHBP_ADDR_W-1:0] addr;
      logic [15:0]            wdata;
      logic [15:0]            rdata;
      logic                   isWrite;
      logic [1:0]             sel;
      logic [1:0]             be;
      logic                   done;
      mhbp_state_t            state;
      logic [3:0]             cnt;
      logic [31:0]            rd;
   } mhbp_core_t;

   mhbp_core_t core_reg;
   mhbp_core_t core_next;

   mhbp_pins_if pinsBus ();

   function automatic logic portActive(input logic [3:0] m, input logic [5:0] h);
      return (m == MHBP_MODE_HB16) && (h[MHBP_HBCFG_SUB_LSB +: 4] == MHBP_SUB_MUXED);
   endfunction

   function automatic logic [3:0] selDecode(input logic [1:0] arr, input logic [1:0] s);
      logic [3:0] v;
      v = 4'hf;
      case (arr)
         MHBP_CS_ALE:     v = 4'hf;
         MHBP_CS_ONE:     v = 4'he;
         MHBP_CS_TWO,
         MHBP_CS_ALE_TWO: v = s[0] ? 4'hd : 4'he;
         default:         v = 4'hf;
      endcase
      return v;
   endfunction

   function automatic logic latchUsed(input logic [1:0] arr);
      // latch present in 0x0 and 0x3
      return (arr == MHBP_CS_ALE) || (arr == MHBP_CS_ALE_TWO);
   endfunction

   always_comb begin
      logic active;
      logic useBsel;
      active = portActive(core_reg.mainCfg, core_reg.hbCfg);
      useBsel = core_reg.hbCfg[MHBP_HBCFG_BYTE_LANE_SELECTS_LSB +: 2] != MHBP_BYTE_LANE_SELECTS_NONE;
      core_next = core_reg;
      core_next.rd = 32'h0000_0000;

      pinsBus.adOut        = 16'h0000;
      pinsBus.adOe         = 1'b0;
      pinsBus.upperAddr    = '0;
      pinsBus.latchStrobe  = 1'b0;
      pinsBus.readStrobeN  = 1'b1;
      pinsBus.writeStrobeN = 1'b1;
      pinsBus.selectN      = 4'hf;
      pinsBus.byteSelectN  = 2'h3;

      if (regWrite) begin
         case (regAddr)
            MHBP_ADDR_MAINCFG: core_next.mainCfg = regWdata[3:0];
            MHBP_ADDR_HBCFG:   core_next.hbCfg   = regWdata[5:0];
            MHBP_ADDR_HBCFG2:  core_next.hbCfg2  = regWdata[1:0];
            MHBP_ADDR_ADDRESS: core_next.addr    = regWdata[MHBP_ADDR_W-1:0];
            MHBP_ADDR_WDATA:   core_next.wdata   = regWdata[15:0];
            MHBP_ADDR_CMD: begin
               // commands ignored while busy or port disabled
               if (core_reg.state == MHBP_IDLE && active) begin
                  core_next.isWrite = regWdata[MHBP_CMD_WRITE_BIT];
                  core_next.sel     = regWdata[MHBP_CMD_SEL_LSB +: 2];
                  core_next.be      = useBsel ? regWdata[MHBP_CMD_BE_LSB +: 2] : 2'h3;
                  core_next.done    = 1'b0;
                  core_next.state   = MHBP_ADDRPH;
                  core_next.cnt     = 4'h0;
               end
            end
            default: ;
         endcase
      end

      if (regRead) begin
         case (regAddr)
            MHBP_ADDR_MAINCFG: core_next.rd = {28'h0, core_reg.mainCfg};
            MHBP_ADDR_HBCFG:   core_next.rd = {26'h0, core_reg.hbCfg};
            MHBP_ADDR_HBCFG2:  core_next.rd = {30'h0, core_reg.hbCfg2};
            MHBP_ADDR_ADDRESS: core_next.rd = {4'h0, core_reg.addr};
            MHBP_ADDR_WDATA:   core_next.rd = {16'h0, core_reg.wdata};
            MHBP_ADDR_RDATA:   core_next.rd = {16'h0, core_reg.rdata};
            MHBP_ADDR_STATUS:  core_next.rd = {29'h0, active, core_reg.done,
                                               core_reg.state != MHBP_IDLE};
            default:           core_next.rd = 32'h0000_0000;
         endcase
      end

      if (core_reg.state != MHBP_IDLE) begin
         pinsBus.upperAddr = core_reg.addr[MHBP_ADDR_W-1:16];
         pinsBus.selectN = selDecode(core_reg.hbCfg2, core_reg.sel);
         pinsBus.byteSelectN = useBsel ? ~core_reg.be : 2'h3;
      end

      case (core_reg.state)
         MHBP_IDLE: ;
         MHBP_ADDRPH: begin
            pinsBus.adOut = core_reg.addr[15:0];
            pinsBus.adOe  = 1'b1;
            pinsBus.latchStrobe = latchUsed(core_reg.hbCfg2);
            core_next.cnt = core_reg.cnt + 4'h1;
            if (core_reg.cnt + 4'h1 >= MHBP_ADDR_CYC) begin
               core_next.cnt   = 4'h0;
               core_next.state = MHBP_TURN;
            end
         end
         MHBP_TURN: begin
            core_next.cnt = core_reg.cnt + 4'h1;
            if (core_reg.cnt + 4'h1 >= MHBP_TURN_CYC) begin
               core_next.cnt   = 4'h0;
               core_next.state = MHBP_STROBE;
            end
         end
         MHBP_STROBE: begin
            pinsBus.readStrobeN  = core_reg.isWrite;
            pinsBus.writeStrobeN = ~core_reg.isWrite;
            pinsBus.adOut = core_reg.isWrite ? core_reg.wdata : 16'h0000;
            pinsBus.adOe  = core_reg.isWrite;
            core_next.cnt = core_reg.cnt + 4'h1;
            if (core_reg.cnt + 4'h1 >= MHBP_STRB_CYC) begin
               // sample read data at strobe end
               if (!core_reg.isWrite) begin
                  core_next.rdata = adIn;
               end
               core_next.cnt   = 4'h0;
               core_next.state = MHBP_DONE;
            end
         end
         MHBP_DONE: begin
            core_next.done  = 1'b1;
            core_next.state = MHBP_IDLE;
         end
         default: core_next.state = MHBP_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         core_reg <= '{mainCfg: MHBP_MAINCFG_RST, hbCfg: MHBP_HBCFG_RST, hbCfg2: MHBP_HBCFG2_RST,
                       addr: '0, wdata: 16'h0000, rdata: 16'h0000, isWrite: 1'b0, sel: 2'h0,
                       be: 2'h3, done: 1'b0, state: MHBP_IDLE, cnt: 4'h0, rd: 32'h0000_0000};
      end else begin
         core_reg <= core_next;
      end
   end

   assign regRdata = core_reg.rd;

   mhbp_pin_stage u_pins (
      .mclk         (mclk),
      .rst          (rst),
      .pins         (pinsBus),
      .adOut        (adOut),
      .adOe         (adOe),
      .upperAddr    (upperAddr),
      .latchStrobe  (latchStrobe),
      .readStrobeN  (readStrobeN),
      .writeStrobeN (writeStrobeN),
      .selectN      (selectN),
      .byteSelectN  (byteSelectN)
   );
endmodule

// ==== mhbp_periph.sv ====
`timescale 1ns/100ps
// two peripherals behind an address latch, 16 words each
module mhbp_periph (
   input  logic        mclk,
   input  logic [15:0] adOut,
   input  logic        adOe,
   input  logic        latchStrobe,
   input  logic        readStrobeN,
   input  logic        writeStrobeN,
   input  logic [3:0]  selectN,
   input  logic [1:0]  byteSelectN,
   output logic [15:0] adIn
);
   logic [15:0] mem [32];
   logic [3:0]  lat_reg = 4'h0;
   logic [15:0] last_reg = 16'h0;
   logic [4:0]  idx;
   logic [1:0]  lane;
   initial foreach (mem[i]) mem[i] = 16'h0;
   assign idx = {~selectN[1], lat_reg};
   // no lanes on pins means full word
   assign lane = byteSelectN == 2'h3 ? 2'h3 : ~byteSelectN;
   always @(posedge mclk) begin
      if ((latchStrobe || adOe) && readStrobeN && writeStrobeN) lat_reg <= adOut[3:0];
      if (!writeStrobeN && lane[0]) mem[idx][7:0] <= adOut[7:0];
      if (!writeStrobeN && lane[1]) mem[idx][15:8] <= adOut[15:8];
      if (!readStrobeN) last_reg <= mem[idx];
   end
   // drive only in read; released lines show inverse
   assign adIn = !readStrobeN ? mem[idx] : ~last_reg;
endmodule

// ==== mhbp_pin_stage.sv ====
`timescale 1ns/100ps
// output flop stage so every pin leaves straight from a flip-flop
module mhbp_pin_stage
   import mhbp_pkg::*;
(
   input  wire logic                    mclk,
   input  wire logic                    rst,
   mhbp_pins_if.sink                    pins,
   output      logic [15:0]             adOut,
   output      logic                    adOe,
   output      logic [MHBP_UPPER_W-1:0] upperAddr,
   output      logic                    latchStrobe,
   output      logic                    readStrobeN,
   output      logic                    writeStrobeN,
   output      logic [3:0]              selectN,
   output      logic [1:0]              byteSelectN
);
   import mhbp_pkg::*;

   typedef struct packed {
      logic [15:0]             ad;
      logic                    oe;
      logic [MHBP_UPPER_W-1:0] up;
      logic                    ale;
      logic                    rdN;
      logic                    wrN;
      logic [3:0]              csN;
      logic [1:0]              bsN;
   } mhbp_pin_t;

   mhbp_pin_t pin_reg;
   mhbp_pin_t pin_next;

   always_comb begin
      pin_next.ad  = pins.adOut;
      pin_next.oe  = pins.adOe;
      pin_next.up  = pins.upperAddr;
      pin_next.ale = pins.latchStrobe;
      pin_next.rdN = pins.readStrobeN;
      pin_next.wrN = pins.writeStrobeN;
      pin_next.csN = pins.selectN;
      pin_next.bsN = pins.byteSelectN;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_reg <= '{ad: 16'h0000, oe: 1'b0, up: '0, ale: 1'b0, rdN: 1'b1, wrN: 1'b1,
                      csN: 4'hf, bsN: 2'h3};
      end else begin
         pin_reg <= pin_next;
      end
   end

   assign adOut        = pin_reg.ad;
   assign adOe         = pin_reg.oe;
   assign upperAddr    = pin_reg.up;
   assign latchStrobe  = pin_reg.ale;
   assign readStrobeN  = pin_reg.rdN;
   assign writeStrobeN = pin_reg.wrN;
   assign selectN      = pin_reg.csN;
   assign byteSelectN  = pin_reg.bsN;
endmodule

// ==== mhbp_pins_if.sv ====
`timescale 1ns/100ps
// pin-side values handed from the sequencer to the pin register stage
interface mhbp_pins_if;
   import mhbp_pkg::*;
   logic [15:0]             adOut;
   logic                    adOe;
   logic [MHBP_UPPER_W-1:0] upperAddr;
   logic                    latchStrobe;
   logic                    readStrobeN;
   logic                    writeStrobeN;
   logic [3:0]              selectN;
   logic [1:0]              byteSelectN;
   modport source (output adOut, adOe, upperAddr, latchStrobe, readStrobeN, writeStrobeN, selectN, byteSelectN);
   modport sink   (input  adOut, adOe, upperAddr, latchStrobe, readStrobeN, writeStrobeN, selectN, byteSelectN);
endinterface

// ==== mhbp_pkg.sv ====
package mhbp_pkg;
   // register map on the plain port (word index = address)
   localparam logic [3:0]  MHBP_ADDR_MAINCFG = 4'h0;
   localparam logic [3:0]  MHBP_ADDR_HBCFG   = 4'h1;
   localparam logic [3:0]  MHBP_ADDR_HBCFG2  = 4'h2;
   localparam logic [3:0]  MHBP_ADDR_ADDRESS = 4'h3;
   localparam logic [3:0]  MHBP_ADDR_WDATA   = 4'h4;
   localparam logic [3:0]  MHBP_ADDR_CMD     = 4'h5;
   localparam logic [3:0]  MHBP_ADDR_RDATA   = 4'h6;
   localparam logic [3:0]  MHBP_ADDR_STATUS  = 4'h7;

   // field values
   localparam logic [3:0]  MHBP_MODE_HB16    = 4'h3;
   localparam logic [3:0]  MHBP_SUB_MUXED    = 4'h0;
   localparam logic [1:0]  MHBP_BYTE_LANE_SELECTS_NONE    = 2'h1;
   localparam logic [1:0]  MHBP_CS_ALE       = 2'h0;
   localparam logic [1:0]  MHBP_CS_ONE       = 2'h1;
   localparam logic [1:0]  MHBP_CS_TWO       = 2'h2;
   localparam logic [1:0]  MHBP_CS_ALE_TWO   = 2'h3;

   // field positions
   localparam int          MHBP_HBCFG_SUB_LSB  = 0;
   localparam int          MHBP_HBCFG_BYTE_LANE_SELECTS_LSB = 4;
   localparam int          MHBP_CMD_WRITE_BIT  = 0;
   localparam int          MHBP_CMD_SEL_LSB    = 1;
   localparam int          MHBP_CMD_BE_LSB     = 3;

   // reset values
   localparam logic [3:0]  MHBP_MAINCFG_RST = 4'h0;
   localparam logic [5:0]  MHBP_HBCFG_RST   = 6'h10;
   localparam logic [1:0]  MHBP_HBCFG2_RST  = 2'h0;

   // phase lengths in mclk cycles
   localparam logic [3:0]  MHBP_ADDR_CYC  = 4'h2;
   localparam logic [3:0]  MHBP_TURN_CYC  = 4'h1;
   localparam logic [3:0]  MHBP_STRB_CYC  = 4'h2;

   localparam int          MHBP_UPPER_W = 12;
   localparam int          MHBP_ADDR_W  = 28;

   typedef enum {
      MHBP_IDLE,
      MHBP_ADDRPH,
      MHBP_TURN,
      MHBP_STROBE,
      MHBP_DONE
   } mhbp_state_t;
endpackage

// ==== tb_muxed_16bit_host_bus_port.sv ====
`timescale 1ns/100ps
module tb_muxed_16bit_host_bus_port;
   import mhbp_pkg::*;
   logic                    mclk = 1'b0;
   logic                    rst = 1'b1;
   logic [3:0]              regAddr = 4'h0;
   logic [31:0]             regWdata = 32'h0;
   logic                    regWrite = 1'b0;
   logic                    regRead = 1'b0;
   logic [31:0]             regRdata, rd;
   logic [15:0]             adIn, adOut;
   logic                    adOe, latchStrobe, readStrobeN, writeStrobeN;
   logic [MHBP_UPPER_W-1:0] upperAddr;
   logic [3:0]              selectN;
   logic [1:0]              byteSelectN;
   logic [15:0]             bmem [int];
   int                      fail_count = 0;
   int                      checks_done = 0;
   always #50 mclk = ~mclk;
   mhbp_host_port uut (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
      .regRead(regRead), .regRdata(regRdata), .adIn(adIn), .adOut(adOut), .adOe(adOe), .upperAddr(upperAddr),
      .latchStrobe(latchStrobe), .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .selectN(selectN),
      .byteSelectN(byteSelectN));
   mhbp_periph far (.mclk(mclk), .adOut(adOut), .adOe(adOe), .latchStrobe(latchStrobe), .readStrobeN(readStrobeN),
      .writeStrobeN(writeStrobeN), .selectN(selectN), .byteSelectN(byteSelectN), .adIn(adIn));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         fail_count++;
      end
   endtask
   task test_done;
      if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask
   task rdr(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask
   task access(input logic [1:0] arr, input logic bsOn, input logic [1:0] be);
      logic [27:0] a;
      logic [15:0] d, m;
      logic [3:0]  sn;
      logic [1:0]  bs, ln;
      logic        s;
      int          n, k;
      a = 28'($urandom);
      s = 1'($urandom);
      sn = arr == MHBP_CS_ALE ? 4'hf : (arr == MHBP_CS_ONE || !s) ? 4'he : 4'hd;
      bs = bsOn ? ~be : 2'h3;
      ln = bsOn ? be : 2'h3;
      k = {sn == 4'hd, a[3:0]};
      wr(MHBP_ADDR_HBCFG2, {30'h0, arr});
      wr(MHBP_ADDR_HBCFG, bsOn ? 32'h0 : 32'h10);
      wr(MHBP_ADDR_ADDRESS, {4'h0, a});
      for (int w = 1; w >= 0; w--) begin
         d = 16'($urandom);
         wr(MHBP_ADDR_WDATA, {16'h0, d});
         wr(MHBP_ADDR_CMD, {27'h0, be, 1'b0, s, w[0]});
         n = 0;
         do begin @(posedge mclk); #1; n++; end while (adOe !== 1'b1 && n < 10);
         check(adOut, a[15:0]);
         check(upperAddr, a[27:16]);
         check(selectN, sn);
         check(byteSelectN, bs);
         check(latchStrobe, arr == MHBP_CS_ALE || arr == MHBP_CS_ALE_TWO);
         do begin @(posedge mclk); #1; n++; end while (readStrobeN && writeStrobeN && n < 20);
         check({readStrobeN, writeStrobeN}, w ? 2'h2 : 2'h1);
         m = bmem.exists(k) ? bmem[k] : 16'h0;
         if (w) check(adOut, d);
         if (w) bmem[k] = {ln[1] ? d[15:8] : m[15:8], ln[0] ? d[7:0] : m[7:0]};
         do begin rdr(MHBP_ADDR_STATUS, rd); n++; end while (rd[1] !== 1'b1 && n < 40);
         check(rd, 32'h6);
         rdr(MHBP_ADDR_RDATA, rd);
         if (!w) check(rd, {16'h0, m});
      end
   endtask
   initial begin
      logic [3:0]  ra [5] = '{4'h0, 4'h1, 4'h2, 4'h7, 4'h9};
      logic [31:0] re [5] = '{32'h0, 32'h10, 32'h0, 32'h0, 32'h0};
      rd = $urandom(32'h202c);
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         rdr(ra[i], rd);
         check(rd, re[i]);
      end
      // off, then on but wrong sub-mode: command must be ignored
      for (int i = 0; i < 2; i++) begin
         wr(MHBP_ADDR_MAINCFG, i ? 32'h3 : 32'h0);
         wr(MHBP_ADDR_HBCFG, i ? 32'h11 : 32'h10);
         wr(MHBP_ADDR_CMD, 32'h1);
         repeat (8) @(posedge mclk);
         rdr(MHBP_ADDR_STATUS, rd);
         check(rd, 32'h0);
      end
      for (int r = 0; r < 2; r++)
         for (int c = 0; c < 8; c++) access(c[2:1], c[0], 2'($urandom_range(1, 3)));
      test_done();
   end
   initial begin
      #1000000;
      fail_count++;
      test_done();
   end
endmodule
